// file: bench/ext_clk_model.sv
// Far-side model: external clock, gate pins and RC oscillator
`timescale 1ns/1ps
`default_nettype none
module ext_clk_model
    import gp_timer_pkg::*;
(
    // Clock
    input wire logic i_clk,
    // Pins, low outside frames
    output logic [NUM_TIMERS-1:0] o_ext,
    output logic o_low_power_rc_oscillator
);
    initial begin
        o_ext = '0;
        o_low_power_rc_oscillator = 1'b0;
    end
    task automatic drive(input int pin, input logic val);
        @(posedge i_clk);
        if (pin == LOW_POWER_RC_OSCILLATOR_PIN) o_low_power_rc_oscillator <= val;
        else o_ext[pin] <= val;
    endtask : drive
    // Slow square wave so the two-stage synchronisers never miss an edge
    task automatic pulse(input int pin, input int n);
        repeat (n) begin
            drive(pin, 1'b1);
            repeat (3) @(posedge i_clk);
            drive(pin, 1'b0);
            repeat (3) @(posedge i_clk);
        end
    endtask : pulse
endmodule : ext_clk_model
`default_nettype wire

// file: bench/tb.sv
// Self-checking testbench for the timer set
`timescale 1ns/1ps
`default_nettype none
module tb;
    import gp_timer_pkg::*;
    logic clk;
    logic rst_n;
    logic ce;
    bus_req_s bus;
    word_t rdata;
    logic [NUM_TIMERS-1:0] ext;
    logic low_power_rc_oscillator;
    logic idle;
    logic irq;
    logic adc;
    int n_fail = 0;
    int samples_checked = 0;
    int n_adc = 0;
    int cycles = 0;
    int n0;
    word_t v;
    word_t mk[3] = '{SA_WMASK, LO_WMASK, HI_WMASK};
    int et[7] = '{0, 0, 0, 0, 1, 4, 1};
    word_t ec[7] = '{16'h8006, 16'h8206, 16'h8006, 16'h8002, 16'h8002,
                     16'h8002, 16'h8042};
    int ep[7] = '{0, 5, 5, 0, 1, 4, 1};
    word_t ee[7] = '{16'h5, 16'h5, 16'h0, 16'h5, 16'h5, 16'h5, 16'h5};
    int dv[4] = '{1, 8, 64, 256};

    gp_timer_set gp_timer_set_i (.I_REF_CLK(clk), .I_RESETN(rst_n),
        .I_CE(ce), .I_BUS(bus), .O_RDATA(rdata), .I_EXT_CLK(ext),
        .I_LOW_POWER_RC_OSCILLATOR_CLK(low_power_rc_oscillator), .I_IDLE(idle), .O_IRQ(irq), .O_ADC_TRIG(adc));
    ext_clk_model ext_clk_model_i (.i_clk(clk), .o_ext(ext), .o_low_power_rc_oscillator(low_power_rc_oscillator));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Hang guard; the whole run needs well under 6000 cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (adc === 1'b1) n_adc <= n_adc + 1;
        if (cycles == 20000) begin
            n_fail++;
            results();
        end
    end

    // ------------------------------------------------------------------
    // Bus tasks and comparisons
    // ------------------------------------------------------------------
    function automatic logic [4:0] ad(input int t, input int o);
        return 5'(REG_STRIDE * t + o);
    endfunction : ad
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    task automatic wr(input logic [4:0] a, input word_t d);
        @(posedge clk);
        bus <= {a, d, 2'b10};
        @(posedge clk);
        bus <= '0;
    endtask : wr
    task automatic rd(input logic [4:0] a);
        @(posedge clk);
        bus <= {a, 16'h0, 2'b01};
        @(posedge clk);
        bus <= '0;
        @(negedge clk);
        v = rdata;
    endtask : rd
    task automatic chk(input string s, input word_t e, input word_t g);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    task automatic rchk(input string s, input logic [4:0] a, input word_t e);
        rd(a);
        chk(s, e, v);
    endtask : rchk
    task automatic rng(input string s, input int t, input int lo,
                       input int hi);
        rd(ad(t, COUNT_OFS));
        chk(s, 16'h1, word_t'((v >= lo) && (v <= hi)));
    endtask : rng
    task automatic irq_is(input logic e);
        @(negedge clk);
        chk("irq", {15'h0, e}, {15'h0, irq});
    endtask : irq_is
    task automatic run(input int t, input word_t c, input word_t p);
        wr(ad(t, COUNT_OFS), 16'h0);
        wr(ad(t, PERIOD_OFS), p);
        wr(ad(t, CTRL_OFS), c);
    endtask : run
    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : results

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        bus = '0;
        rst_n = 1'b0;
        ce = 1'b1;
        idle = 1'b0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 15; i++) rchk("reset", 5'(i), 16'h0);
        rchk("status", STATUS_ADDR, 16'h0);
        for (int t = 0; t < 3; t++) begin
            wr(ad(t, CTRL_OFS), 16'hffff);
            rchk("ctrl mask", ad(t, CTRL_OFS), mk[t]);
            wr(ad(t, CTRL_OFS), 16'h0);
        end
        wr(CLEAR_ADDR, 16'h001f);
        wr(STATUS_ADDR, 16'hffff);
        rchk("status ro", STATUS_ADDR, 16'h0);
        wr(5'h1f, 16'hffff);
        rchk("unmapped", 5'h1f, 16'h0);
        $display("test registers done");
        wr(ENABLE_ADDR, 16'hffff);
        rchk("enable", ENABLE_ADDR, 16'h001f);
        wr(ENABLE_ADDR, 16'h0001);
        run(0, 16'h8000, 16'h0003);
        cyc(8);
        wr(ad(0, CTRL_OFS), 16'h0);
        rchk("match flag", STATUS_ADDR, 16'h0001);
        irq_is(1'b1);
        wr(ENABLE_ADDR, 16'h0);
        irq_is(1'b0);
        wr(ENABLE_ADDR, 16'h0001);
        irq_is(1'b1);
        wr(CLEAR_ADDR, 16'h0001);
        rchk("cleared", STATUS_ADDR, 16'h0);
        irq_is(1'b0);
        $display("test period done");
        for (int c = 0; c < 4; c++) begin
            run(1, 16'h8000 | word_t'(c << 4), 16'hffff);
            cyc(4 * dv[c]);
            wr(ad(1, CTRL_OFS), 16'h0);
            n0 = (4 * dv[c] + 3) / dv[c];
            rng("prescale", 1, n0 - 1, n0 + 1);
        end
        run(1, 16'h8010, 16'hffff);
        cyc(4);
        wr(ad(1, CTRL_OFS), 16'h8010);
        cyc(3);
        wr(ad(1, CTRL_OFS), 16'h0);
        rchk("prescale clear", ad(1, COUNT_OFS), 16'h0);
        $display("test prescale done");
        for (int i = 0; i < 7; i++) begin
            run(et[i], ec[i], 16'hffff);
            ext_clk_model_i.pulse(ep[i], 5);
            cyc(6);
            wr(ad(et[i], CTRL_OFS), 16'h0);
            rchk("ext count", ad(et[i], COUNT_OFS), ee[i]);
        end
        $display("test external done");
        wr(CLEAR_ADDR, 16'h001f);
        run(0, 16'h8040, 16'hffff);
        ext_clk_model_i.drive(0, 1'b1);
        cyc(10);
        ext_clk_model_i.drive(0, 1'b0);
        cyc(6);
        wr(ad(0, CTRL_OFS), 16'h0);
        rng("gated", 0, 8, 13);
        rchk("gate fall", STATUS_ADDR, 16'h0001);
        $display("test gate done");
        @(posedge clk);
        idle <= 1'b1;
        run(1, 16'ha000, 16'hffff);
        cyc(20);
        rchk("idle stop", ad(1, COUNT_OFS), 16'h0);
        wr(ad(1, CTRL_OFS), 16'h8000);
        cyc(10);
        rng("idle run", 1, 5, 40);
        @(posedge clk);
        idle <= 1'b0;
        wr(ad(1, CTRL_OFS), 16'h0);
        $display("test idle done");
        wr(CLEAR_ADDR, 16'h001f);
        n0 = n_adc;
        wr(ad(1, COUNT_OFS), 16'hfffe);
        wr(ad(2, COUNT_OFS), 16'h0);
        wr(ad(1, PERIOD_OFS), 16'h0001);
        wr(ad(2, PERIOD_OFS), 16'h0001);
        wr(ad(1, CTRL_OFS), 16'h8008);
        cyc(8);
        wr(ad(1, CTRL_OFS), 16'h0008);
        rchk("cascade flag", STATUS_ADDR, 16'h0004);
        rchk("high word", ad(2, COUNT_OFS), 16'h0);
        chk("adc cascade", 16'h1, word_t'(n_adc - n0));
        wr(ad(1, CTRL_OFS), 16'h0);
        wr(CLEAR_ADDR, 16'h001f);
        n0 = n_adc;
        run(3, 16'h8000, 16'h0002);
        cyc(10);
        wr(ad(3, CTRL_OFS), 16'h0);
        chk("adc pair1", 16'h0, word_t'(n_adc - n0));
        rchk("pair1 flag", STATUS_ADDR, 16'h0008);
        run(2, 16'h8000, 16'h0002);
        cyc(10);
        wr(ad(2, CTRL_OFS), 16'h0);
        chk("adc high", 16'h1, word_t'(n_adc - n0 >= 2));
        $display("test cascade done");
        run(0, 16'h8000, 16'hffff);
        @(posedge clk);
        ce <= 1'b0;
        cyc(20);
        ce <= 1'b1;
        wr(ad(0, CTRL_OFS), 16'h0);
        rng("freeze", 0, 2, 4);
        $display("test freeze done");
        results();
    end
endmodule : tb
`default_nettype wire

// file: core/gp_timer_pkg.sv
// Shared constants, types and register layout of the general purpose timer set
package gp_timer_pkg;

    typedef logic [15:0] word_t;
    typedef logic [7:0] pscnt_t;

    // ------------------------------------------------------------------
    // Timer slots and pin slots
    // ------------------------------------------------------------------
    localparam int NUM_TIMERS = 5;
    localparam int NUM_PINS = 6;
    localparam int SA_IDX = 0;
    localparam int P0_LO_IDX = 1;
    localparam int P0_HI_IDX = 2;
    localparam int P1_LO_IDX = 3;
    localparam int P1_HI_IDX = 4;
    localparam int LOW_POWER_RC_OSCILLATOR_PIN = 5;

    // ------------------------------------------------------------------
    // Register map (word addresses)
    // ------------------------------------------------------------------
    localparam int REG_STRIDE = 3;
    localparam int CTRL_OFS = 0;
    localparam int COUNT_OFS = 1;
    localparam int PERIOD_OFS = 2;
    localparam logic [4:0] STATUS_ADDR = 5'h0f;
    localparam logic [4:0] CLEAR_ADDR = 5'h10;
    localparam logic [4:0] ENABLE_ADDR = 5'h11;

    // ------------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------------
    localparam int RUN_BIT = 15;
    localparam int IDLE_BIT = 13;
    localparam int EXT_HI = 9;
    localparam int EXT_LO = 8;
    localparam int GATE_BIT = 6;
    localparam int PS_HI = 5;
    localparam int PS_LO = 4;
    localparam int CASCADE_BIT = 3;
    localparam int SYNC_BIT = 2;
    localparam int CS_BIT = 1;
    localparam logic [1:0] EXT_LOW_POWER_RC_OSCILLATOR = 2'h2;
    localparam logic [1:0] PS_DIV256 = 2'h3;
    localparam logic [1:0] PS_DIV64 = 2'h2;
    localparam logic [1:0] PS_DIV8 = 2'h1;
    localparam pscnt_t DIV256_M1 = 8'hff;
    localparam pscnt_t DIV64_M1 = 8'h3f;
    localparam pscnt_t DIV8_M1 = 8'h07;
    localparam pscnt_t DIV1_M1 = 8'h00;
    localparam word_t SA_WMASK = 16'ha376;
    localparam word_t LO_WMASK = 16'ha07a;
    localparam word_t HI_WMASK = 16'ha072;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [4:0] addr;
        word_t wdata;
        logic wr;
        logic rd;
    } bus_req_s;

    typedef struct packed {
        word_t [NUM_TIMERS-1:0] ctrl;
        word_t [NUM_TIMERS-1:0] count;
        word_t [NUM_TIMERS-1:0] period;
        pscnt_t [NUM_TIMERS-1:0] pscnt;
        logic [NUM_PINS-1:0] pin_s1;
        logic [NUM_PINS-1:0] pin_s2;
        logic [NUM_PINS-1:0] pin_s3;
        logic idle_s1;
        logic idle_s2;
        logic [NUM_TIMERS-1:0] status;
        logic [NUM_TIMERS-1:0] enable;
        word_t rdata;
        logic irq;
        logic adc;
    } state_s;

    localparam state_s STATE_RST = '0;

endpackage : gp_timer_pkg

// file: core/gp_timer_set.sv
// Five 16-bit timers: one standalone, two cascadable pairs
//
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module gp_timer_set
    import gp_timer_pkg::*;
(
    // Clock, reset, enable
    input wire logic I_REF_CLK,
    input wire logic I_RESETN,
    input wire logic I_CE,
    // Register port
    input wire bus_req_s I_BUS,
    output wire word_t O_RDATA,
    // Pins and system state
    input wire logic [NUM_TIMERS-1:0] I_EXT_CLK,
    input wire logic I_LOW_POWER_RC_OSCILLATOR_CLK,
    input wire logic I_IDLE,
    // Events
    output wire logic O_IRQ,
    output wire logic O_ADC_TRIG
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    state_s r;
    state_s n;

    logic [NUM_TIMERS-1:0] on;
    logic [NUM_TIMERS-1:0] src_tick;
    logic [NUM_TIMERS-1:0] tick;
    logic [NUM_TIMERS-1:0] gated;
    logic [NUM_TIMERS-1:0] fall;
    pscnt_t [NUM_TIMERS-1:0] div_m1;
    logic [1:0] casc;

    assign casc[0] = r.ctrl[P0_LO_IDX][CASCADE_BIT];
    assign casc[1] = r.ctrl[P1_LO_IDX][CASCADE_BIT];

    function automatic word_t wmask(input int idx);
        if (idx == SA_IDX) begin
            return SA_WMASK;
        end else if (idx % 2 == 1) begin
            return LO_WMASK;
        end
        return HI_WMASK;
    endfunction : wmask

    // ------------------------------------------------------------------
    // Per-timer clock selection and prescale
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NUM_TIMERS; g++) begin : g_tmr
            word_t c;
            logic use_low_power_rc_oscillator;
            logic ext_rise;
            int src;
            assign c = r.ctrl[g];
            // Idle-stop gates the run bit
            assign on[g] = c[RUN_BIT]
                && !(r.idle_s2 && c[IDLE_BIT]);
            // Field stays zero on paired timers, so only slot 0 sees it
            assign use_low_power_rc_oscillator = (c[EXT_HI:EXT_LO] == EXT_LOW_POWER_RC_OSCILLATOR);
            assign src = use_low_power_rc_oscillator ? LOW_POWER_RC_OSCILLATOR_PIN : g;
            // One clock only: async mode also counts synchronised edges,
            // so a stopped reference clock stops async counting as well
            assign ext_rise = r.pin_s2[src]
                && !r.pin_s3[src];
            assign gated[g] = !c[CS_BIT] && c[GATE_BIT];
            always_comb begin
                if (c[CS_BIT]) begin
                    src_tick[g] = ext_rise;
                end else begin
                    src_tick[g] = !gated[g] || r.pin_s2[g];
                end
            end
            assign fall[g] = on[g] && gated[g] && !r.pin_s2[g]
                && r.pin_s3[g];
            always_comb begin
                case (c[PS_HI:PS_LO])
                    PS_DIV256: div_m1[g] = DIV256_M1;
                    PS_DIV64: div_m1[g] = DIV64_M1;
                    PS_DIV8: div_m1[g] = DIV8_M1;
                    default: div_m1[g] = DIV1_M1;
                endcase
            end
            assign tick[g] = on[g] && src_tick[g]
                && (r.pscnt[g] == div_m1[g]);
        end
    endgenerate

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    logic [NUM_TIMERS-1:0] ev;
    logic [NUM_TIMERS-1:0] mev;

    always_comb begin
        logic [31:0] c32;
        logic in_casc;
        logic lo_casc;
        int lo;
        int hi;
        c32 = '0;
        in_casc = 1'b0;
        lo_casc = 1'b0;
        lo = 0;
        hi = 0;
        n = r;
        ev = '0;
        mev = '0;
        n.pin_s1 = {I_LOW_POWER_RC_OSCILLATOR_CLK, I_EXT_CLK};
        n.pin_s2 = r.pin_s1;
        n.pin_s3 = r.pin_s2;
        n.idle_s1 = I_IDLE;
        n.idle_s2 = r.idle_s1;
        for (int i = 0; i < NUM_TIMERS; i++) begin
            lo_casc = (i == P0_LO_IDX && casc[0])
                || (i == P1_LO_IDX && casc[1]);
            in_casc = lo_casc || (i == P0_HI_IDX && casc[0])
                || (i == P1_HI_IDX && casc[1]);
            // Prescaler is held clear while stopped
            if (!on[i]) begin
                n.pscnt[i] = '0;
            end else if (src_tick[i]) begin
                n.pscnt[i] = (r.pscnt[i] == div_m1[i]) ? '0
                    : 8'(r.pscnt[i] + 8'h01);
            end
            if (tick[i] && !in_casc) begin
                if (r.count[i] == r.period[i]) begin
                    n.count[i] = '0;
                    mev[i] = 1'b1;
                    ev[i] = !gated[i];
                end else begin
                    n.count[i] = r.count[i] + 16'h0001;
                end
            end
            // A gated cascade reports its gate edge on the high flag
            if (fall[i] && !(in_casc && !lo_casc)) begin
                ev[lo_casc ? i + 1 : i] = 1'b1;
            end
        end
        for (int p = 0; p < 2; p++) begin
            lo = P0_LO_IDX + 2 * p;
            hi = lo + 1;
            if (casc[p] && tick[lo]) begin
                if ({r.count[hi], r.count[lo]}
                    == {r.period[hi], r.period[lo]}) begin
                    n.count[hi] = '0;
                    n.count[lo] = '0;
                    mev[hi] = 1'b1;
                    ev[hi] = !gated[lo];
                end else begin
                    c32 = {r.count[hi], r.count[lo]} + 32'h1;
                    n.count[hi] = c32[31:16];
                    n.count[lo] = c32[15:0];
                end
            end
        end
        // Software writes win over counting in the same cycle
        for (int i = 0; i < NUM_TIMERS; i++) begin
            if (I_BUS.wr && I_BUS.addr == 5'(i*REG_STRIDE+CTRL_OFS)) begin
                n.ctrl[i] = I_BUS.wdata & wmask(i);
                if (on[i]) begin
                    n.pscnt[i] = '0;
                end
            end
            if (I_BUS.wr && I_BUS.addr == 5'(i*REG_STRIDE+COUNT_OFS)) begin
                n.count[i] = I_BUS.wdata;
            end
            if (I_BUS.wr && I_BUS.addr == 5'(i*REG_STRIDE+PERIOD_OFS)) begin
                n.period[i] = I_BUS.wdata;
            end
        end
        if (I_BUS.wr && I_BUS.addr == ENABLE_ADDR) begin
            n.enable = I_BUS.wdata[NUM_TIMERS-1:0];
        end
        // Set beats clear so an event on the clear cycle survives
        n.status = r.status | ev;
        if (I_BUS.wr && I_BUS.addr == CLEAR_ADDR) begin
            n.status = (r.status & ~I_BUS.wdata[NUM_TIMERS-1:0]) | ev;
        end
        n.rdata = '0;
        if (I_BUS.rd) begin
            for (int i = 0; i < NUM_TIMERS; i++) begin
                if (I_BUS.addr == 5'(i*REG_STRIDE+CTRL_OFS)) begin
                    n.rdata = r.ctrl[i];
                end
                if (I_BUS.addr == 5'(i*REG_STRIDE+COUNT_OFS)) begin
                    n.rdata = r.count[i];
                end
                if (I_BUS.addr == 5'(i*REG_STRIDE+PERIOD_OFS)) begin
                    n.rdata = r.period[i];
                end
            end
            if (I_BUS.addr == STATUS_ADDR) begin
                n.rdata = {11'h000, r.status};
            end
            if (I_BUS.addr == ENABLE_ADDR) begin
                n.rdata = {11'h000, r.enable};
            end
        end
        n.irq = |(n.status & n.enable);
        n.adc = mev[P0_HI_IDX];
    end

    always_ff @(posedge I_REF_CLK) begin
        if (!I_RESETN) begin
            r <= STATE_RST;
        end else if (I_CE) begin
            r <= n;
        end
    end

    assign O_RDATA = r.rdata;
    assign O_IRQ = r.irq;
    assign O_ADC_TRIG = r.adc;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    logic wr_cnt0;
    logic wr_cnt1;
    logic wr_cnt2;
    logic wr_any;
    assign wr_cnt0 = I_BUS.wr && I_BUS.addr == 5'(SA_IDX*REG_STRIDE+COUNT_OFS);
    assign wr_cnt1 = I_BUS.wr
        && I_BUS.addr == 5'(P0_LO_IDX*REG_STRIDE+COUNT_OFS);
    assign wr_cnt2 = I_BUS.wr
        && I_BUS.addr == 5'(P0_HI_IDX*REG_STRIDE+COUNT_OFS);
    assign wr_any = I_BUS.wr;

    default clocking @(posedge I_REF_CLK); endclocking
    default disable iff (!I_RESETN);

    sequence s_sa_match;
        I_CE && tick[SA_IDX] && !gated[SA_IDX] && !wr_any
            && r.count[SA_IDX] == r.period[SA_IDX];
    endsequence

    sequence s_casc_match;
        I_CE && casc[0] && tick[P0_LO_IDX] && !gated[P0_LO_IDX] && !wr_any
            && {r.count[P0_HI_IDX], r.count[P0_LO_IDX]}
            == {r.period[P0_HI_IDX], r.period[P0_LO_IDX]};
    endsequence

    // ------------------------------------------------------------------
    // Carry and trigger steps
    // ------------------------------------------------------------------
    sequence s_lo_carry;
        I_CE && casc[0] && tick[P0_LO_IDX] && !wr_any
            && r.count[P0_LO_IDX] == 16'hffff
            && r.period[P0_HI_IDX] != r.count[P0_HI_IDX];
    endsequence

    sequence s_hi_match;
        I_CE && !casc[0] && tick[P0_HI_IDX] && !wr_any
            && r.count[P0_HI_IDX] == r.period[P0_HI_IDX];
    endsequence

    sequence s_casc1_match;
        I_CE && casc[1] && tick[P1_LO_IDX] && !gated[P1_LO_IDX] && !wr_any
            && {r.count[P1_HI_IDX], r.count[P1_LO_IDX]}
            == {r.period[P1_HI_IDX], r.period[P1_LO_IDX]};
    endsequence

    a_stop_holds: assert property (
        I_CE && !on[SA_IDX] && !wr_cnt0 |=> $stable(r.count[SA_IDX]))
        else $error("stopped timer counted");
    a_period_wrap: assert property (
        s_sa_match |=> r.count[SA_IDX] == 16'h0000 && r.status[SA_IDX])
        else $error("period match did not wrap and flag");
    a_gate_flag: assert property (
        I_CE && fall[SA_IDX] |=> r.status[SA_IDX])
        else $error("gate falling edge did not flag");
    a_gate_hold: assert property (
        I_CE && gated[SA_IDX] && !r.pin_s2[SA_IDX] && !wr_cnt0
        |=> $stable(r.count[SA_IDX]))
        else $error("gated timer counted with gate low");
    a_prescale_range: assert property (
        r.pscnt[SA_IDX] <= div_m1[SA_IDX])
        else $error("prescaler ran past its divide");
    a_ctrl_clear: assert property (
        I_CE && on[SA_IDX] && I_BUS.wr
        && I_BUS.addr == 5'(SA_IDX*REG_STRIDE+CTRL_OFS)
        |=> r.pscnt[SA_IDX] == 8'h00)
        else $error("control write did not clear prescaler");
    a_idle_stop: assert property (
        I_CE && r.idle_s2 && r.ctrl[SA_IDX][IDLE_BIT] && !wr_cnt0
        |=> $stable(r.count[SA_IDX]))
        else $error("timer ran in idle with stop bit set");
    a_casc_wrap: assert property (
        s_casc_match |=> r.count[P0_HI_IDX] == 16'h0000
        && r.count[P0_LO_IDX] == 16'h0000 && r.status[P0_HI_IDX])
        else $error("32-bit match did not wrap and flag high");
    a_high_ignored: assert property (
        I_CE && casc[0] && !tick[P0_LO_IDX] && !wr_cnt1 && !wr_cnt2
        |=> $stable(r.count[P0_HI_IDX]) && !r.status[P0_LO_IDX]
        || $past(r.status[P0_LO_IDX]))
        else $error("cascaded high word moved on its own");
    a_adc_source: assert property (
        I_CE |=> O_ADC_TRIG == $past(mev[P0_HI_IDX]))
        else $error("ADC trigger not from first pair high");

    // ------------------------------------------------------------------
    // Counting, edges and triggers
    // ------------------------------------------------------------------
    a_count_step: assert property (
        I_CE && tick[SA_IDX] && !wr_any
        && r.count[SA_IDX] != r.period[SA_IDX]
        |=> r.count[SA_IDX] == $past(r.count[SA_IDX]) + 16'h0001)
        else $error("running timer did not step by one");
    a_casc_carry: assert property (
        s_lo_carry |=> r.count[P0_LO_IDX] == 16'h0000
        && r.count[P0_HI_IDX] == $past(r.count[P0_HI_IDX]) + 16'h0001)
        else $error("low word wrap did not carry into high word");
    a_low_quiet: assert property (
        I_CE && casc[0] && !wr_any && !r.status[P0_LO_IDX]
        |=> !r.status[P0_LO_IDX])
        else $error("cascaded pair set its low flag");
    a_pin_edge: assert property (
        I_CE && r.ctrl[P0_LO_IDX][CS_BIT] && !wr_cnt1
        && !(r.pin_s2[P0_LO_IDX] && !r.pin_s3[P0_LO_IDX])
        |=> $stable(r.count[P0_LO_IDX]))
        else $error("pin clocked timer counted without an edge");
    a_low_power_rc_oscillator_edge: assert property (
        I_CE && r.ctrl[SA_IDX][CS_BIT] && !wr_cnt0
        && r.ctrl[SA_IDX][EXT_HI:EXT_LO] == EXT_LOW_POWER_RC_OSCILLATOR
        && !(r.pin_s2[LOW_POWER_RC_OSCILLATOR_PIN] && !r.pin_s3[LOW_POWER_RC_OSCILLATOR_PIN])
        |=> $stable(r.count[SA_IDX]))
        else $error("RC clocked timer counted without an edge");
    a_gate_count: assert property (
        I_CE && on[SA_IDX] && gated[SA_IDX] && r.pin_s2[SA_IDX]
        && div_m1[SA_IDX] == DIV1_M1 && !wr_any
        && r.count[SA_IDX] != r.period[SA_IDX]
        |=> r.count[SA_IDX] == $past(r.count[SA_IDX]) + 16'h0001)
        else $error("gated timer held with gate high");
    a_adc_16bit: assert property (
        s_hi_match |=> O_ADC_TRIG)
        else $error("first pair high match gave no trigger");
    a_adc_32bit: assert property (
        s_casc_match |=> O_ADC_TRIG)
        else $error("32-bit match gave no trigger");
    a_casc1_wrap: assert property (
        s_casc1_match |=> r.count[P1_HI_IDX] == 16'h0000
        && r.count[P1_LO_IDX] == 16'h0000 && r.status[P1_HI_IDX])
        else $error("second pair 32-bit match did not wrap and flag");
    a_idle_run: assert property (
        r.ctrl[SA_IDX][RUN_BIT] && !r.ctrl[SA_IDX][IDLE_BIT] |-> on[SA_IDX])
        else $error("timer without stop bit halted in idle");
    a_stop_prescale: assert property (
        I_CE && !on[SA_IDX] |=> r.pscnt[SA_IDX] == 8'h00)
        else $error("stopped prescaler did not clear");

endmodule : gp_timer_set

`default_nettype wire
